/* a429_tx_pkg.sv */
// Shared constants and types for the serial word transmitter and its host
package a429_tx_pkg;
  localparam int CORE_CLK_HZ   = 250_000_000;
  localparam int DATA_CLK_HZ   = 1_000_000;
  localparam int DATA_CLK_DIV  = CORE_CLK_HZ / DATA_CLK_HZ;
  // Timing in data clocks
  localparam int HS_HALF_CLKS  = 5;
  localparam int HS_GAP_CLKS   = 40;
  localparam int LS_HALF_CLKS  = 40;
  localparam int LS_GAP_CLKS   = 320;
  localparam int WORD_BITS     = 32;
  localparam int FIFO_DEPTH    = 32;
  localparam int FIFO_HALF     = 16;
  localparam int LABEL_COUNT   = 16;
  // Control word bit positions
  localparam int CB_MODE       = 0;
  localparam int CB_MATCH      = 1;
  localparam int CB_PARITY     = 2;
  localparam int CB_LOOP_N     = 3;
  localparam int CB_POL        = 4;
  localparam int CB_RATE       = 5;
  localparam int CB_REPEAT     = 6;
  localparam int CTRL_BITS     = 7;
  localparam logic [6:0] CTRL_RST = 7'h0C;
  // Host register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TXWORD = 8'h04;
  localparam logic [7:0] REG_RXCMD  = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LINE   = 8'h14;
  localparam int HOST_STROBE_CLKS   = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_DATA = 2'h1, TX_NULL = 2'h3, TX_GAP = 2'h2
  } tx_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_SETUP = 2'h1, H_STROBE = 2'h3, H_HOLD = 2'h2
  } host_state_t;
  typedef enum logic [1:0] {
    OP_CTRL = 2'h0, OP_LO = 2'h1, OP_HI = 2'h3, OP_RD = 2'h2
  } host_op_t;
endpackage

/* a429_tx_if.sv */
// Parallel bus and flag pins between host and transmitter device
`timescale 1ns/10ps
`default_nettype none
interface a429_tx_if;
  logic [15:0] dbus_host;
  logic        dbus_host_oe;
  logic [15:0] dbus_dev;
  logic        dbus_dev_oe;
  logic [15:0] dbus;
  logic        ctrl_write_n;
  logic        load_strobe_half1_n;
  logic        load_strobe_half2_n;
  logic        rx1_read_strobe_n;
  logic        rx2_read_strobe_n;
  logic        half_word_select;
  logic        transmit_go;
  logic        output_null_force;
  logic        tx_fifo_full_flag;
  logic        tx_fifo_half_flag;
  logic        tx_fifo_empty_flag;
  // Wire level of the shared data bus; an undriven bus reads all ones
  assign dbus = dbus_dev_oe ? dbus_dev : (dbus_host_oe ? dbus_host : 16'hFFFF);
  modport device (
    input  dbus, ctrl_write_n, load_strobe_half1_n, load_strobe_half2_n,
    input  rx1_read_strobe_n, rx2_read_strobe_n, half_word_select,
    input  transmit_go, output_null_force,
    output dbus_dev, dbus_dev_oe,
    output tx_fifo_full_flag, tx_fifo_half_flag, tx_fifo_empty_flag
  );
  modport host (
    input  dbus, tx_fifo_full_flag, tx_fifo_half_flag, tx_fifo_empty_flag,
    output dbus_host, dbus_host_oe, ctrl_write_n,
    output load_strobe_half1_n, load_strobe_half2_n,
    output rx1_read_strobe_n, rx2_read_strobe_n, half_word_select,
    output transmit_go, output_null_force
  );
endinterface
`default_nettype wire

/* tx_word_fifo.sv */
// First-in first-out word store with occupancy count
`timescale 1ns/10ps
`default_nettype none
module tx_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           push_data,
  input  wire logic                       pop,
  output logic      [WIDTH-1:0]           pop_data,
  output logic      [$clog2(DEPTH+1)-1:0] count,
  output logic                            full,
  output logic                            empty
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } fifo_state_t;
  fifo_state_t q, d;
  logic do_push, do_pop;

  assign full     = (q.cnt == CW'(DEPTH));
  assign empty    = (q.cnt == '0);
  assign count    = q.cnt;
  assign pop_data = q.mem[q.rp];

  always_comb begin
    d       = q;
    do_push = push & ~full;
    do_pop  = pop & ~empty;
    if (do_push) begin
      d.mem[q.wp] = push_data;
      d.wp        = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    end
    if (do_pop) begin
      d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

/* a429_tx_device.sv */
// Transmitter device end: bus decode, label read-back, FIFO and serialiser
//
// How it works
// - Sixteen reads after mode rise return labels
// - Host holds select high, accesses sixteen
// - Host keeps label matching off during read-back
// - First half then second half loads word
// - Stored word 31 bits with parity, else 32
// - Thirty-two words; full flag; excess loads ignored
// - Half flag high below sixteen words
// - Parity bit makes total odd or even
// - Parity off sends all 32 bits unchanged
// - Go moves oldest word out quickly
// - High speed: 5 data, 5 null, 40 gap
// - Low speed: 40 data, 40 null, 320 gap
// - Empty flag when all words sent; here set once the last word leaves the FIFO to start sending
// - Rate bit picks 100k or 12.5k
// - Loopback feeds receivers, second one inverted
// - Null force holds lines null always
// - Repeater reads lower half first
// - Repeater reads also load transmit FIFO
// - Select low first half, high second
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module a429_tx_device (
  input  wire logic        core_clk,
  input  wire logic        rst,
  a429_tx_if.device        bus,
  input  wire logic [31:0] rx1_word,
  input  wire logic [31:0] rx2_word,
  output logic             line_out_a,
  output logic             line_out_b,
  output logic             loop_rx1_a,
  output logic             loop_rx1_b,
  output logic             loop_rx2_a,
  output logic             loop_rx2_b,
  output logic             label_match_enable,
  output logic             rx1_pop,
  output logic             rx2_pop
);
  localparam int DW = $clog2(a429_tx_pkg::DATA_CLK_DIV);
  typedef struct packed {
    logic [a429_tx_pkg::CTRL_BITS-1:0] ctrl;
    logic [4:0]                        strb;
    logic [15:0]                       lo;
    logic [1:0][4:0]                   lcnt;
    logic [1:0][3:0]                   lwr;
    logic [1:0][15:0][7:0]             lab;
    logic [15:0]                       rd;
    logic                              oe;
    logic [1:0]                        pop;
    logic [DW-1:0]                     div;
    a429_tx_pkg::tx_state_t            st;
    logic [8:0]                        tcnt;
    logic [4:0]                        bitn;
    logic [31:0]                       sh;
    logic                              la;
    logic                              lb;
    logic                              ka;
    logic                              kb;
  } dev_state_t;
  dev_state_t q, d;

  logic [4:0]  cur, fall;
  logic        mode, tick, push, pop, full, empty, a, b;
  logic [31:0] push_word, word, fifo_word;
  logic [5:0]  fcount;
  logic [8:0]  half_clks, gap_clks;

  tx_word_fifo #(
    .WIDTH (a429_tx_pkg::WORD_BITS),
    .DEPTH (a429_tx_pkg::FIFO_DEPTH)
  ) fifo_i (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (push),
    .push_data (push_word),
    .pop       (pop),
    .pop_data  (fifo_word),
    .count     (fcount),
    .full      (full),
    .empty     (empty)
  );

  always_comb begin
    d    = q;
    cur  = {bus.ctrl_write_n, bus.rx2_read_strobe_n, bus.rx1_read_strobe_n,
            bus.load_strobe_half2_n, bus.load_strobe_half1_n};
    fall = q.strb & ~cur;
    d.strb = cur;
    d.pop  = '0;
    mode   = q.ctrl[a429_tx_pkg::CB_MODE];
    push   = 1'b0;
    pop    = 1'b0;
    word   = '0;
    push_word = '0;
    a      = 1'b0;
    b      = 1'b0;
    if (fall[4]) begin
      d.ctrl = bus.dbus[a429_tx_pkg::CTRL_BITS-1:0];
      if (!mode && bus.dbus[a429_tx_pkg::CB_MODE]) begin
        d.lcnt = '0;
        d.lwr  = '0;
      end
    end
    if (fall[0]) begin
      if (mode) begin
        d.lab[0][q.lwr[0]] = bus.dbus[7:0];
        d.lwr[0]           = q.lwr[0] + 1'b1;
      end else begin
        d.lo = bus.dbus;
      end
    end
    if (fall[1]) begin
      if (mode) begin
        d.lab[1][q.lwr[1]] = bus.dbus[7:0];
        d.lwr[1]           = q.lwr[1] + 1'b1;
      end else begin
        push      = 1'b1;
        push_word = {bus.dbus, q.lo};
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (fall[2+i]) begin
        word = (i == 0) ? rx1_word : rx2_word;
        if (mode && q.lcnt[i] < 5'(a429_tx_pkg::LABEL_COUNT)) begin
          d.rd      = {8'h00, q.lab[i][q.lcnt[i][3:0]]};
          d.lcnt[i] = q.lcnt[i] + 1'b1;
        end else if (bus.half_word_select) begin
          d.rd     = word[31:16];
          d.pop[i] = 1'b1;
          if (q.ctrl[a429_tx_pkg::CB_REPEAT]) begin
            push      = 1'b1;
            push_word = {word[31:16], q.lo};
          end
        end else begin
          d.rd = word[15:0];
          if (q.ctrl[a429_tx_pkg::CB_REPEAT]) begin
            d.lo = word[15:0];
          end
        end
      end
    end
    d.oe = (|fall[3:2]) | (q.oe & ~(&cur[3:2]));
    if (q.ctrl[a429_tx_pkg::CB_PARITY]) begin
      push_word[31] = 1'b0;
    end

    // Data clock enable
    tick  = (q.div == DW'(a429_tx_pkg::DATA_CLK_DIV - 1));
    d.div = tick ? '0 : q.div + 1'b1;
    if (q.ctrl[a429_tx_pkg::CB_RATE]) begin
      half_clks = 9'(a429_tx_pkg::LS_HALF_CLKS);
      gap_clks  = 9'(a429_tx_pkg::LS_GAP_CLKS);
    end else begin
      half_clks = 9'(a429_tx_pkg::HS_HALF_CLKS);
      gap_clks  = 9'(a429_tx_pkg::HS_GAP_CLKS);
    end
    if (tick) begin
      d.tcnt = q.tcnt - 1'b1;
      case (q.st)
        a429_tx_pkg::TX_IDLE: begin
          if (bus.transmit_go && !empty) begin
            pop  = 1'b1;
            d.sh = fifo_word;
            if (q.ctrl[a429_tx_pkg::CB_PARITY]) begin
              // Odd total when polarity low, even when high
              d.sh[31] = ~(^fifo_word[30:0]) ^
                         q.ctrl[a429_tx_pkg::CB_POL];
            end
            d.st   = a429_tx_pkg::TX_DATA;
            d.tcnt = half_clks - 1'b1;
            d.bitn = '0;
          end
        end
        a429_tx_pkg::TX_DATA: begin
          if (q.tcnt == '0) begin
            d.st   = a429_tx_pkg::TX_NULL;
            d.tcnt = half_clks - 1'b1;
          end
        end
        a429_tx_pkg::TX_NULL: begin
          if (q.tcnt == '0) begin
            d.sh   = q.sh >> 1;
            d.bitn = q.bitn + 1'b1;
            d.tcnt = half_clks - 1'b1;
            d.st   = a429_tx_pkg::TX_DATA;
            if (q.bitn == 5'(a429_tx_pkg::WORD_BITS - 1)) begin
              d.st   = a429_tx_pkg::TX_GAP;
              d.tcnt = gap_clks - 1'b1;
            end
          end
        end
        a429_tx_pkg::TX_GAP: begin
          if (q.tcnt == '0) begin
            d.st = a429_tx_pkg::TX_IDLE;
          end
        end
        default: begin
          d.st = a429_tx_pkg::TX_IDLE;
        end
      endcase
    end
    if (d.st == a429_tx_pkg::TX_DATA) begin
      a = d.sh[0];
      b = ~d.sh[0];
    end
    if (q.ctrl[a429_tx_pkg::CB_LOOP_N]) begin
      d.ka = 1'b0;
      d.kb = 1'b0;
      d.la = a;
      d.lb = b;
    end else begin
      d.ka = a;
      d.kb = b;
      d.la = 1'b0;
      d.lb = 1'b0;
    end
    if (bus.output_null_force) begin
      d.la = 1'b0;
      d.lb = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.ctrl <= a429_tx_pkg::CTRL_RST;
      q.strb <= 5'h1F;
    end else begin
      q <= d;
    end
  end

  assign bus.dbus_dev           = q.rd;
  assign bus.dbus_dev_oe        = q.oe;
  assign bus.tx_fifo_full_flag  = full;
  assign bus.tx_fifo_half_flag  = (fcount < 6'(a429_tx_pkg::FIFO_HALF));
  assign bus.tx_fifo_empty_flag = empty;
  assign line_out_a         = q.la;
  assign line_out_b         = q.lb;
  assign loop_rx1_a         = q.ka;
  assign loop_rx1_b         = q.kb;
  assign loop_rx2_a         = q.kb;
  assign loop_rx2_b         = q.ka;
  assign label_match_enable = q.ctrl[a429_tx_pkg::CB_MATCH];
  assign rx1_pop            = q.pop[0];
  assign rx2_pop            = q.pop[1];
endmodule
`default_nettype wire

/* a429_tx_host.sv */
// Host end: AXI4-Lite register slave that drives the parallel bus pins
`timescale 1ns/10ps
`default_nettype none
module a429_tx_host (
  input  wire logic        core_clk,
  input  wire logic        rst,
  a429_tx_if.host          bus,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  typedef struct packed {
    logic                    aw;
    logic [7:0]              awa;
    logic                    w;
    logic [31:0]             wd;
    logic                    bv;
    logic [1:0]              br;
    logic                    rv;
    logic [1:0]              rr;
    logic [31:0]             rd;
    logic [6:0]              ctrl;
    logic [1:0]              line;
    logic [1:0]              rxsel;
    logic [31:0]             txw;
    logic [15:0]             rxd;
    a429_tx_pkg::host_state_t st;
    a429_tx_pkg::host_op_t    op;
    logic [1:0]              cnt;
  } host_state_all_t;
  host_state_all_t q, d;
  logic strobe, busy;

  always_comb begin
    d    = q;
    busy = (q.st != a429_tx_pkg::H_IDLE);
    if (awvalid && !q.aw) begin
      d.aw  = 1'b1;
      d.awa = awaddr;
    end
    if (wvalid && !q.w) begin
      d.w  = 1'b1;
      d.wd = wdata;
    end
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end
    if (q.aw && q.w && !q.bv && !busy) begin
      d.aw = 1'b0;
      d.w  = 1'b0;
      d.bv = 1'b1;
      d.br = a429_tx_pkg::RESP_OKAY;
      case (q.awa)
        a429_tx_pkg::REG_CTRL: begin
          d.ctrl = q.wd[6:0];
          if (q.wd[a429_tx_pkg::CB_MODE]) begin
            d.ctrl[a429_tx_pkg::CB_MATCH] = 1'b0;
          end
          d.op = a429_tx_pkg::OP_CTRL;
          d.st = a429_tx_pkg::H_SETUP;
        end
        a429_tx_pkg::REG_TXWORD: begin
          d.txw = q.wd;
          d.op  = a429_tx_pkg::OP_LO;
          d.st  = a429_tx_pkg::H_SETUP;
        end
        a429_tx_pkg::REG_RXCMD: begin
          d.rxsel = q.wd[1:0];
          d.op    = a429_tx_pkg::OP_RD;
          d.st    = a429_tx_pkg::H_SETUP;
        end
        a429_tx_pkg::REG_LINE: begin
          d.line = q.wd[1:0];
        end
        default: begin
          d.br = a429_tx_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q.rv && rready) begin
      d.rv = 1'b0;
    end
    if (arvalid && !q.rv) begin
      d.rv = 1'b1;
      d.rr = a429_tx_pkg::RESP_OKAY;
      case (araddr)
        a429_tx_pkg::REG_CTRL:   d.rd = {25'h0, q.ctrl};
        a429_tx_pkg::REG_TXWORD: d.rd = q.txw;
        a429_tx_pkg::REG_RXCMD:  d.rd = {30'h0, q.rxsel};
        a429_tx_pkg::REG_RXDATA: d.rd = {16'h0, q.rxd};
        a429_tx_pkg::REG_STATUS: d.rd = {28'h0, busy,
                                   bus.tx_fifo_empty_flag,
                                   bus.tx_fifo_half_flag,
                                   bus.tx_fifo_full_flag};
        a429_tx_pkg::REG_LINE:   d.rd = {30'h0, q.line};
        default: begin
          d.rd = '0;
          d.rr = a429_tx_pkg::RESP_SLVERR;
        end
      endcase
    end
    case (q.st)
      a429_tx_pkg::H_IDLE: begin
        d.cnt = '0;
      end
      a429_tx_pkg::H_SETUP: begin
        d.st  = a429_tx_pkg::H_STROBE;
        d.cnt = 2'(a429_tx_pkg::HOST_STROBE_CLKS - 1);
      end
      a429_tx_pkg::H_STROBE: begin
        d.cnt = q.cnt - 1'b1;
        if (q.cnt == '0) begin
          d.st = a429_tx_pkg::H_HOLD;
          if (q.op == a429_tx_pkg::OP_RD) begin
            d.rxd = bus.dbus;
          end
        end
      end
      a429_tx_pkg::H_HOLD: begin
        d.st = a429_tx_pkg::H_IDLE;
        if (q.op == a429_tx_pkg::OP_LO) begin
          d.op = a429_tx_pkg::OP_HI;
          d.st = a429_tx_pkg::H_SETUP;
        end
      end
      default: begin
        d.st = a429_tx_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.ctrl <= a429_tx_pkg::CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign strobe  = (q.st == a429_tx_pkg::H_STROBE);
  assign awready = ~q.aw;
  assign wready  = ~q.w;
  assign bvalid  = q.bv;
  assign bresp   = q.br;
  assign arready = ~q.rv;
  assign rvalid  = q.rv;
  assign rresp   = q.rr;
  assign rdata   = q.rd;
  assign bus.dbus_host    = (q.op == a429_tx_pkg::OP_CTRL) ? {9'h0, q.ctrl} :
                            (q.op == a429_tx_pkg::OP_HI) ? q.txw[31:16] :
                            q.txw[15:0];
  assign bus.dbus_host_oe = busy && (q.op != a429_tx_pkg::OP_RD);
  assign bus.ctrl_write_n = ~(strobe && q.op == a429_tx_pkg::OP_CTRL);
  assign bus.load_strobe_half1_n = ~(strobe && q.op == a429_tx_pkg::OP_LO);
  assign bus.load_strobe_half2_n = ~(strobe && q.op == a429_tx_pkg::OP_HI);
  assign bus.rx1_read_strobe_n   =
    ~(strobe && q.op == a429_tx_pkg::OP_RD && !q.rxsel[0]);
  assign bus.rx2_read_strobe_n   =
    ~(strobe && q.op == a429_tx_pkg::OP_RD && q.rxsel[0]);
  // Label sequences need select high; otherwise it picks the half
  assign bus.half_word_select = q.ctrl[a429_tx_pkg::CB_MODE] | q.rxsel[1];
  assign bus.transmit_go       = q.line[0];
  assign bus.output_null_force = q.line[1];
endmodule
`default_nettype wire

/* a429_tx_monitor.sv */
// Checker of line code, FIFO flags, word timing and bus turn-around
`timescale 1ns/10ps
`default_nettype none
module a429_tx_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx1_read_strobe_n,
  input wire logic rx2_read_strobe_n,
  input wire logic dbus_dev_oe,
  input wire logic transmit_go,
  input wire logic output_null_force,
  input wire logic tx_fifo_full_flag,
  input wire logic tx_fifo_half_flag,
  input wire logic tx_fifo_empty_flag,
  input wire logic line_out_a,
  input wire logic line_out_b
);
  localparam logic [15:0] HALF =
    16'(a429_tx_pkg::HS_HALF_CLKS * a429_tx_pkg::DATA_CLK_DIV);
  localparam logic [15:0] GAP =
    HALF + 16'(a429_tx_pkg::HS_GAP_CLKS * a429_tx_pkg::DATA_CLK_DIV);
  logic        act;
  logic [15:0] run_q;
  logic [15:0] nul_q;
  assign act = line_out_a | line_out_b;
  // Reset counts as a long idle, so the first word may start at once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_q <= 16'h0;
      nul_q <= 16'hFFFF;
    end else begin
      run_q <= act ? run_q + 16'h1 : 16'h0;
      nul_q <= act ? 16'h0 : ((&nul_q) ? nul_q : nul_q + 16'h1);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_line_code;
    !(line_out_a && line_out_b);
  endproperty
  a_line_code: assert property (p_line_code)
    else $error("both line outputs high");
  property p_force_null;
    output_null_force [*2] |-> !line_out_a && !line_out_b;
  endproperty
  a_force_null: assert property (p_force_null)
    else $error("line not null while forced");
  property p_full_flags;
    tx_fifo_full_flag |-> !tx_fifo_half_flag && !tx_fifo_empty_flag;
  endproperty
  a_full_flags: assert property (p_full_flags)
    else $error("full flag with half or empty flag");
  property p_empty_half;
    tx_fifo_empty_flag |-> tx_fifo_half_flag;
  endproperty
  a_empty_half: assert property (p_empty_half)
    else $error("empty fifo without half flag");
  property p_data_half;
    $fell(act) |-> run_q == HALF;
  endproperty
  a_data_half: assert property (p_data_half)
    else $error("data half length wrong");
  property p_null_gap;
    $rose(act) |-> nul_q == HALF || nul_q >= GAP;
  endproperty
  a_null_gap: assert property (p_null_gap)
    else $error("null half or word gap length wrong");
  property p_start_go;
    $rose(act) && nul_q >= GAP |-> $past(transmit_go) || $past(transmit_go, 2);
  endproperty
  a_start_go: assert property (p_start_go)
    else $error("word started without transmit enable");
  property p_oe_cause;
    $rose(dbus_dev_oe) |-> $past(!rx1_read_strobe_n || !rx2_read_strobe_n);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("device drove bus without read strobe");
endmodule
`default_nettype wire

/* serial_avionics_word_transmitter_bench.sv */
// Self-checking bench joining host and device ends over the parallel bus, driving the host over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module serial_avionics_word_transmitter_bench;
  logic        core_clk, rst, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rx1_word, rx2_word, seed, rd_v, d, w;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        line_out_a, line_out_b, loop_rx1_a, loop_rx1_b;
  logic        loop_rx2_a, loop_rx2_b, label_match_enable, rx1_pop, rx2_pop;
  logic [31:0] q[$];
  logic [7:0]  lab[2][16];
  int          bad_count, cmp_count, cyc, i, r, n, pops1, pops2;
  logic        act_any;
  a429_tx_if bus ();
  a429_tx_device i_a429_tx_device (.core_clk(core_clk), .rst(rst),
    .bus(bus), .rx1_word(rx1_word), .rx2_word(rx2_word),
    .line_out_a(line_out_a), .line_out_b(line_out_b),
    .loop_rx1_a(loop_rx1_a), .loop_rx1_b(loop_rx1_b),
    .loop_rx2_a(loop_rx2_a), .loop_rx2_b(loop_rx2_b),
    .label_match_enable(label_match_enable), .rx1_pop(rx1_pop),
    .rx2_pop(rx2_pop));
  // Any bit on the line or on the loopback path
  assign act_any = line_out_a | line_out_b | loop_rx1_a | loop_rx1_b;
  a429_tx_host i_a429_tx_host (.core_clk(core_clk), .rst(rst), .bus(bus),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  a429_tx_monitor i_a429_tx_monitor (.core_clk(core_clk), .rst(rst),
    .rx1_read_strobe_n(bus.rx1_read_strobe_n),
    .rx2_read_strobe_n(bus.rx2_read_strobe_n),
    .dbus_dev_oe(bus.dbus_dev_oe), .transmit_go(bus.transmit_go),
    .output_null_force(bus.output_null_force),
    .tx_fifo_full_flag(bus.tx_fifo_full_flag),
    .tx_fifo_half_flag(bus.tx_fifo_half_flag),
    .tx_fifo_empty_flag(bus.tx_fifo_empty_flag),
    .line_out_a(line_out_a), .line_out_b(line_out_b));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Poll status until the pin sequencer has finished its bus cycle
  task automatic idle();
    do rd(a429_tx_pkg::REG_STATUS);
    while (rd_v[3] !== 1'b0);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (rx1_pop === 1'b1) pops1++;
    if (rx2_pop === 1'b1) pops2++;
    if (cyc == 100000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    {rst, seed} = {1'b1, 32'h97AA63CA};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    {rx1_word, rx2_word} = 64'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rx1_word <= xs();
    rx2_word <= xs();
    rd(a429_tx_pkg::REG_CTRL);
    chk("ctrl", rd_v, 32'h0C);
    rd(a429_tx_pkg::REG_STATUS);
    chk("status", rd_v[2:0], 3'h6);
    rd(8'h20);
    chk("resp", rs, a429_tx_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(a429_tx_pkg::REG_CTRL, 32'h0F);
    idle();
    chk("match", label_match_enable, 1'b0);
    for (i = 0; i < 16; i++) begin
      d = xs();
      lab[0][i] = d[7:0];
      lab[1][i] = d[23:16];
      wr(a429_tx_pkg::REG_TXWORD, d);
    end
    rd(a429_tx_pkg::REG_STATUS);
    chk("empty", rd_v[2], 1'b1);
    for (r = 0; r < 2; r++)
      for (i = 0; i < 17; i++) begin
        wr(a429_tx_pkg::REG_RXCMD, {30'h0, 1'b1, r[0]});
        idle();
        rd(a429_tx_pkg::REG_RXDATA);
        w = r ? rx2_word : rx1_word;
        d = (i < 16) ? {24'h0, lab[r][i]} : {16'h0, w[31:16]};
        chk("label", rd_v[15:0], d);
      end
    wr(a429_tx_pkg::REG_CTRL, 32'h0C);
    $display("test label done");
    wr(a429_tx_pkg::REG_CTRL, 32'h4C);
    wr(a429_tx_pkg::REG_RXCMD, 32'h0);
    wr(a429_tx_pkg::REG_RXCMD, 32'h2);
    q.push_back(rx1_word & 32'h7FFFFFFF);
    wr(a429_tx_pkg::REG_CTRL, 32'h1C);
    for (i = 0; i < 32; i++) begin
      d = xs();
      wr(a429_tx_pkg::REG_TXWORD, d);
      if (q.size() < 32) q.push_back(d & 32'h7FFFFFFF);
      idle();
      chk("flags", rd_v[2:0], {1'b0, q.size() < 16, q.size() == 32});
    end
    chk("pop1", pops1, 2);
    chk("pop2", pops2, 1);
    wr(a429_tx_pkg::REG_LINE, 32'h2);
    repeat (4) @(posedge core_clk);
    chk("force", {line_out_a, line_out_b}, 2'h0);
    wr(a429_tx_pkg::REG_LINE, 32'h0);
    $display("test fill done");
    w = q[0];
    w[31] = ^w[30:0];
    wr(a429_tx_pkg::REG_LINE, 32'h1);
    n = 0;
    while (!(line_out_a | line_out_b)) begin
      @(posedge core_clk);
      n++;
    end
    chk("start", n <= 625, 1'b1);
    for (i = 0; i < 32; i++) begin
      rs = w[i] ? 2'h2 : 2'h1;
      while (!act_any) @(posedge core_clk);
      chk("bit", {line_out_a, line_out_b}, (i < 28) ? rs : 2'h0);
      d = {loop_rx1_a, loop_rx1_b, loop_rx2_a, loop_rx2_b};
      chk("loop", d[3:0], (i < 28) ? 4'h0 : {rs, ~rs});
      if (i == 0) wr(a429_tx_pkg::REG_LINE, 32'h0);
      while (act_any) @(posedge core_clk);
      // Last four bits go round the loopback path, switched in a null half
      if (i == 27) wr(a429_tx_pkg::REG_CTRL, 32'h14);
    end
    n = 0;
    repeat (12000) begin
      @(posedge core_clk);
      if (act_any) n++;
    end
    chk("idle", n, 0);
    rd(a429_tx_pkg::REG_STATUS);
    chk("left", rd_v[2:0], 3'h0);
    $display("test transmit done");
    test_done();
  end
endmodule
`default_nettype wire
